//--- line_err_pkg.sv
`default_nettype none
package line_err_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h31;
  localparam logic [7:0] ADDR_IE     = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h3b;
  localparam logic [7:0] ADDR_CNT_LO = 8'h3c;
  localparam logic [7:0] ADDR_CNT_HI = 8'h3d;

  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] IE_RESET    = 8'h00;
  localparam logic [7:0] CTRL_MASK   = 8'h7f;
  localparam logic [7:0] IE_MASK     = 8'h1f;
  localparam logic [7:0] STATUS_MASK = 8'h1f;

  // Control register fields.
  localparam int CTRL_ZERO_STD = 0;
  localparam int CTRL_MODE     = 1;
  localparam int CTRL_STOP     = 2;
  localparam int CTRL_VIOLATION_INSERT_TRIGGER  = 3;
  localparam int CTRL_LE_INS   = 4;
  localparam int CTRL_SEL_LO   = 5;
  localparam int CTRL_SEL_HI   = 6;

  // Interrupt status and enable fields share positions.
  localparam int ST_PRBS  = 0;
  localparam int ST_VIOL  = 1;
  localparam int ST_EXZ   = 2;
  localparam int ST_TIMER = 3;
  localparam int ST_OVF   = 4;

  // Error select codes.
  localparam logic [1:0] SEL_PRBS = 2'h0;
  localparam logic [1:0] SEL_VIOL = 2'h1;
  localparam logic [1:0] SEL_EXZ  = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;

  typedef enum logic [1:0] {
    CODE_AMI  = 2'h0,
    CODE_HDB3 = 2'h1,
    CODE_B8ZS = 2'h2
  } line_code_e;

  // Longest legal zero runs; one more zero is an error.
  localparam logic [6:0] ZL_AMI_ANSI = 7'h0f;
  localparam logic [6:0] ZL_AMI_FCC  = 7'h50;
  localparam logic [6:0] ZL_HDB3     = 7'h03;
  localparam logic [6:0] ZL_B8ZS     = 7'h07;
  localparam logic [6:0] ZL_SAT      = 7'h7f;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int REPORT_TIME_MS = 1000;
  localparam int SECOND_CYCLES  = REPORT_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // --------------------------------------------------------------------------
  // Symbol carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic mark;
    logic pol;
    logic subst;
  } rx_sym_s;

  typedef struct packed {
    logic valid;
    logic mark;
    logic pol;
    logic prbs;
  } tx_sym_s;

endpackage : line_err_pkg
`default_nettype wire

//--- line_error_detector.sv
`default_nettype none
module line_error_detector (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   ce,
  input  wire line_err_pkg::line_code_e coding,
  input  wire logic                   zero_std,
  input  wire line_err_pkg::rx_sym_s  rx,
  output logic                        bpv_err,
  output logic                        cv_err,
  output logic                        exz_err
);

  // --------------------------------------------------------------------------
  // Polarity and zero-run tracking
  // --------------------------------------------------------------------------
  logic       have_mark;
  logic       last_pol;
  logic       viol_seen;
  logic       last_viol_pol;
  logic [6:0] zero_run;

  function automatic logic [6:0] zero_limit(input line_err_pkg::line_code_e c,
                                             input logic fcc);
    if (c == line_err_pkg::CODE_HDB3) begin
      zero_limit = line_err_pkg::ZL_HDB3;
    end else if (c == line_err_pkg::CODE_B8ZS) begin
      zero_limit = line_err_pkg::ZL_B8ZS;
    end else begin
      zero_limit = fcc ? line_err_pkg::ZL_AMI_FCC : line_err_pkg::ZL_AMI_ANSI;
    end
  endfunction : zero_limit

  // A repeated polarity is a violation; substituted codes only err on a repeat.
  wire mark_in   = ce & rx.valid & rx.mark;
  wire zero_in   = ce & rx.valid & ~rx.mark;
  wire same_pol  = mark_in & have_mark & (rx.pol == last_pol);
  wire is_ami    = (coding == line_err_pkg::CODE_AMI);
  wire bpv_now   = is_ami & same_pol;
  wire cv_now    = ~is_ami & same_pol & ~rx.subst & viol_seen
                   & (rx.pol == last_viol_pol);
  wire exz_now   = zero_in & (zero_run == zero_limit(coding, zero_std));
  wire [6:0] run_inc = (zero_run == line_err_pkg::ZL_SAT) ? zero_run : zero_run + 7'h01;

  // Tracking state follows every received symbol.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      have_mark     <= 1'b0;
      last_pol      <= 1'b0;
      viol_seen     <= 1'b0;
      last_viol_pol <= 1'b0;
      zero_run      <= 7'h00;
    end else if (mark_in) begin
      have_mark <= 1'b1;
      last_pol  <= rx.pol;
      zero_run  <= 7'h00;
      if (same_pol) begin
        viol_seen     <= 1'b1;
        last_viol_pol <= rx.pol;
      end
    end else if (zero_in) begin
      zero_run <= run_inc;
    end
  end

  // Error pulses are registered so each lasts one cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bpv_err <= 1'b0;
      cv_err  <= 1'b0;
      exz_err <= 1'b0;
    end else if (ce) begin
      bpv_err <= bpv_now;
      cv_err  <= cv_now;
      exz_err <= exz_now;
    end
  end

endmodule : line_error_detector
`default_nettype wire

//--- line_error_counter_injector.sv
// What this block does
// - In AMI, two successive marks of equal polarity flag a bipolar violation.
// - In HDB3/B8ZS, repeated non-substitution violations of equal polarity flag a code violation.
// - AMI zero runs above 15 (ANSI) or 80 (FCC) flag excess zeros.
// - HDB3 runs above 3 and B8ZS runs above 7 zeros flag excess zeros.
// - Two-bit select picks one error type; value 11 counts violations and zeros.
// - Select 00 counts received pattern logic errors.
// - Selected errors accumulate in a 16-bit counter.
// - Each error sets its status bit and raises interrupt unless masked.
// - Mode bit 1 is automatic, 0 manual; changing the mode bit restarts counting.
// - Single-rail mode pulses the violation output high one cycle per violation.
// - Automatic mode copies, clears and restarts the counter at each second.
// - Errors arriving in the copy cycle go into the next period.
// - Each second sets the timer status; interrupt raised while enable bit is 0.
// - Reading interrupt status clears the error status bits.
// - Counter overflow sets overflow status; interrupt unless its enable masks it.
// - Manual mode: rising stop bit copies then clears the counter.
// - Rising insert bit inverts middle of three successive transmit marks once.
// - Rising logic-error insert bit flips one transmitted pattern bit.
`default_nettype none
module line_error_counter_injector #(
  parameter int CNT_W         = 16,
  parameter int SECOND_CYCLES = line_err_pkg::SECOND_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic                     ce,
  input  wire line_err_pkg::line_code_e coding,
  input  wire logic                     single_rail,
  input  wire line_err_pkg::rx_sym_s    rx_sym,
  input  wire logic                     prbs_error,
  input  wire line_err_pkg::tx_sym_s    tx_in,
  output line_err_pkg::tx_sym_s         tx_out,
  output logic                          violation_pulse_output,
  output logic                          irq,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic [7:0]                    reg_rdata
);

  localparam int TMR_W = $clog2(SECOND_CYCLES);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(SECOND_CYCLES - 1);

  // --------------------------------------------------------------------------
  // Registers and strobes
  // --------------------------------------------------------------------------
  logic [7:0]       error_counter_control;
  logic [7:0]       error_interrupt_enable;
  logic [7:0]       error_interrupt_status;
  logic [CNT_W-1:0] counter;
  logic [CNT_W-1:0] snapshot;
  logic [TMR_W-1:0] sec_timer;
  logic             bpv_armed;
  logic             le_armed;
  line_err_pkg::tx_sym_s s0;
  line_err_pkg::tx_sym_s s1;
  logic bpv_err;
  logic cv_err;
  logic exz_err;

  wire wr_ctrl   = ce & reg_wr & (reg_addr == line_err_pkg::ADDR_CTRL);
  wire wr_ie     = ce & reg_wr & (reg_addr == line_err_pkg::ADDR_IE);
  wire rd_status = ce & reg_rd & (reg_addr == line_err_pkg::ADDR_STATUS);

  wire zero_run_standard_select = error_counter_control[line_err_pkg::CTRL_ZERO_STD];
  wire counter_report_mode      = error_counter_control[line_err_pkg::CTRL_MODE];
  wire counter_stop_trigger     = error_counter_control[line_err_pkg::CTRL_STOP];
  wire [1:0] err_sel = error_counter_control[line_err_pkg::CTRL_SEL_HI:line_err_pkg::CTRL_SEL_LO];

  // Triggers act on a 0-to-1 write, so software must return them to 0 first.
  function automatic logic rise_on_write(input logic wr, input logic old_v, input logic new_v);
    rise_on_write = wr & ~old_v & new_v;
  endfunction : rise_on_write

  wire stop_rise = rise_on_write(wr_ctrl, counter_stop_trigger,
                                 reg_wdata[line_err_pkg::CTRL_STOP]);
  wire violation_insert_trigger_rise = rise_on_write(wr_ctrl, error_counter_control[line_err_pkg::CTRL_VIOLATION_INSERT_TRIGGER],
                                    reg_wdata[line_err_pkg::CTRL_VIOLATION_INSERT_TRIGGER]);
  wire le_ins_rise = rise_on_write(wr_ctrl, error_counter_control[line_err_pkg::CTRL_LE_INS],
                                   reg_wdata[line_err_pkg::CTRL_LE_INS]);
  // Only a change of the mode bit restarts counting; a stop write must still transfer.
  wire mode_written = wr_ctrl
                      & (reg_wdata[line_err_pkg::CTRL_MODE] != counter_report_mode);

  // Control and enable registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      error_counter_control  <= line_err_pkg::CTRL_RESET;
      error_interrupt_enable <= line_err_pkg::IE_RESET;
    end else begin
      if (wr_ctrl) error_counter_control <= reg_wdata & line_err_pkg::CTRL_MASK;
      if (wr_ie) error_interrupt_enable <= reg_wdata & line_err_pkg::IE_MASK;
    end
  end

  // --------------------------------------------------------------------------
  // Receive error detection
  // --------------------------------------------------------------------------
  line_error_detector u_detector (
    .clk      (clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .coding   (coding),
    .zero_std (zero_run_standard_select),
    .rx       (rx_sym),
    .bpv_err  (bpv_err),
    .cv_err   (cv_err),
    .exz_err  (exz_err)
  );

  wire viol_ev = ce & (bpv_err | cv_err);
  wire exz_ev  = ce & exz_err;
  wire prbs_ev = ce & prbs_error;

  // Both-type selection can add two errors in one cycle.
  function automatic logic [1:0] count_inc(input logic [1:0] sel, input logic p,
                                           input logic v, input logic z);
    unique case (sel)
      line_err_pkg::SEL_PRBS: count_inc = {1'b0, p};
      line_err_pkg::SEL_VIOL: count_inc = {1'b0, v};
      line_err_pkg::SEL_EXZ:  count_inc = {1'b0, z};
      line_err_pkg::SEL_BOTH: count_inc = {1'b0, v} + {1'b0, z};
    endcase
  endfunction : count_inc

  wire [1:0]     inc   = count_inc(err_sel, prbs_ev, viol_ev, exz_ev);
  wire [CNT_W:0] sum   = {1'b0, counter} + (CNT_W + 1)'(inc);

  // --------------------------------------------------------------------------
  // One-second timer and counter reporting
  // --------------------------------------------------------------------------
  wire sec_expire = ce & (sec_timer == TMR_LAST);
  wire transfer   = ~mode_written & (counter_report_mode ? sec_expire : stop_rise);
  wire overflow   = ~mode_written & ~transfer & sum[CNT_W];

  wire [CNT_W-1:0] next_counter = mode_written ? '0 :
                                  transfer ? CNT_W'(inc) :
                                  sum[CNT_W-1:0];

  // The timer restarts with the mode write so a period starts cleanly.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_timer <= '0;
    end else if (mode_written | sec_expire) begin
      sec_timer <= '0;
    end else if (ce) begin
      sec_timer <= sec_timer + TMR_W'(1);
    end
  end

  // A single snapshot feeds both count bytes, so low and high never tear.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      counter  <= '0;
      snapshot <= '0;
    end else if (ce) begin
      counter <= next_counter;
      if (transfer) snapshot <= counter;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------------
  wire [7:0] status_set = {3'h0, overflow, sec_expire, exz_ev, viol_ev, prbs_ev};
  wire [7:0] status_clr = rd_status ? line_err_pkg::STATUS_MASK : 8'h00;
  wire [7:0] next_status = (error_interrupt_status & ~status_clr) | status_set;

  // A set arriving with the clearing read survives it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      error_interrupt_status <= 8'h00;
    end else if (ce) begin
      error_interrupt_status <= next_status;
    end
  end

  // The timer enable is active low; the others are active high.
  wire [4:0] ie_eff = {error_interrupt_enable[line_err_pkg::ST_OVF],
                       ~error_interrupt_enable[line_err_pkg::ST_TIMER],
                       error_interrupt_enable[2:0]};
  assign irq = |(error_interrupt_status[4:0] & ie_eff);

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  wire [7:0] rd_mux = (reg_addr == line_err_pkg::ADDR_CTRL)   ? error_counter_control :
                      (reg_addr == line_err_pkg::ADDR_IE)     ? error_interrupt_enable :
                      (reg_addr == line_err_pkg::ADDR_STATUS) ? error_interrupt_status :
                      (reg_addr == line_err_pkg::ADDR_CNT_LO) ? snapshot[7:0] :
                      (reg_addr == line_err_pkg::ADDR_CNT_HI) ? snapshot[CNT_W-1:8] :
                      8'h00;

  // Read data is held until the next read; unmapped offsets return zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (ce & reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // Violation pin pulses one cycle per violation in single-rail operation.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      violation_pulse_output <= 1'b0;
    end else if (ce) begin
      violation_pulse_output <= single_rail & (bpv_err | cv_err);
    end
  end

  // --------------------------------------------------------------------------
  // Transmit error insertion
  // --------------------------------------------------------------------------
  // Two symbols are held back so the middle of three marks can be altered.
  wire shift     = ce & tx_in.valid;
  wire bpv_apply = bpv_armed & shift & tx_in.mark & s0.valid & s0.mark
                   & s1.valid & s1.mark;
  wire le_apply  = le_armed & shift;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bpv_armed <= 1'b0;
      le_armed  <= 1'b0;
      s0        <= '0;
      s1        <= '0;
      tx_out    <= '0;
    end else if (ce) begin
      bpv_armed <= violation_insert_trigger_rise | (bpv_armed & ~bpv_apply);
      le_armed  <= le_ins_rise | (le_armed & ~le_apply);
      tx_out.valid <= 1'b0;
      if (shift) begin
        s0 <= '{valid: 1'b1, mark: tx_in.mark, pol: tx_in.pol,
                prbs: tx_in.prbs ^ le_apply};
        s1 <= '{valid: s0.valid, mark: s0.mark, pol: s0.pol ^ bpv_apply, prbs: s0.prbs};
        tx_out <= '{valid: s1.valid, mark: s1.mark, pol: s1.pol, prbs: s1.prbs};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_auto_expire;
    counter_report_mode & sec_expire & ~mode_written;
  endsequence

  property p_auto_copy;
    @(posedge clk) disable iff (!arst_n)
    s_auto_expire |=> (snapshot == $past(counter)) && (counter == CNT_W'($past(inc)));
  endproperty
  a_auto_copy: assert property (p_auto_copy) else $error("auto copy wrong");

  property p_manual_copy;
    @(posedge clk) disable iff (!arst_n)
    (~counter_report_mode & stop_rise & ~mode_written) |=> (snapshot == $past(counter));
  endproperty
  a_manual_copy: assert property (p_manual_copy) else $error("manual copy wrong");

  property p_manual_no_timer_copy;
    @(posedge clk) disable iff (!arst_n)
    (~counter_report_mode & ~stop_rise & ce) |=> (snapshot == $past(snapshot));
  endproperty
  a_manual_no_timer_copy: assert property (p_manual_no_timer_copy)
    else $error("snapshot changed without trigger");

  property p_timer_status;
    @(posedge clk) disable iff (!arst_n)
    sec_expire |=> error_interrupt_status[line_err_pkg::ST_TIMER];
  endproperty
  a_timer_status: assert property (p_timer_status) else $error("timer status not set");

  property p_timer_irq;
    @(posedge clk) disable iff (!arst_n)
    (error_interrupt_status[line_err_pkg::ST_TIMER]
     & ~error_interrupt_enable[line_err_pkg::ST_TIMER]) |-> irq;
  endproperty
  a_timer_irq: assert property (p_timer_irq) else $error("timer irq missing");

  property p_read_clears;
    @(posedge clk) disable iff (!arst_n)
    (rd_status & ~viol_ev) |=> ~error_interrupt_status[line_err_pkg::ST_VIOL];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared");

  property p_set_wins;
    @(posedge clk) disable iff (!arst_n)
    viol_ev |=> error_interrupt_status[line_err_pkg::ST_VIOL];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("violation status lost");

  property p_overflow;
    @(posedge clk) disable iff (!arst_n)
    (ce & (&counter) & (inc != 2'h0) & ~transfer & ~mode_written)
      |=> error_interrupt_status[line_err_pkg::ST_OVF] && (counter < CNT_W'(2));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_viol_pulse;
    @(posedge clk) disable iff (!arst_n)
    (ce & single_rail & bpv_err & ~cv_err) |=> violation_pulse_output;
  endproperty
  a_viol_pulse: assert property (p_viol_pulse) else $error("violation pin missing");

  property p_count_prbs;
    @(posedge clk) disable iff (!arst_n)
    (ce & (err_sel == line_err_pkg::SEL_PRBS) & prbs_error & ~transfer & ~mode_written
     & ~(&counter)) |=> (counter == $past(counter) + CNT_W'(1));
  endproperty
  a_count_prbs: assert property (p_count_prbs) else $error("pattern error not counted");

  property p_bpv_insert;
    @(posedge clk) disable iff (!arst_n)
    bpv_apply |=> (s1.pol != $past(s0.pol)) && ~bpv_armed;
  endproperty
  a_bpv_insert: assert property (p_bpv_insert) else $error("violation insert wrong");

  property p_le_insert;
    @(posedge clk) disable iff (!arst_n)
    le_apply |=> (s0.prbs != $past(tx_in.prbs)) && ~le_armed;
  endproperty
  a_le_insert: assert property (p_le_insert) else $error("logic error insert wrong");

endmodule : line_error_counter_injector
`default_nettype wire

//--- line_partner.sv
`default_nettype none
module line_partner (
  input  wire logic              clk,
  output line_err_pkg::rx_sym_s  rx_sym,
  output line_err_pkg::tx_sym_s  tx_in,
  output logic                   prbs_error
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Decoder and encoder symbol sources
  // ----------------------------------------------------------------------
  // Outside a strobe the fields carry the inverse of the last symbol.
  // A design that samples without valid then sees wrong data.
  initial begin
    rx_sym = '0;
    tx_in = '0;
    prbs_error = 1'b0;
  end

  // One received bit, one cycle wide.
  task automatic send_rx(input logic m, input logic p, input logic s);
    @(posedge clk);
    rx_sym <= {1'b1, m, p, s};
    @(posedge clk);
    rx_sym <= {1'b0, ~m, ~p, ~s};
  endtask : send_rx

  // One transmit bit, one cycle wide.
  task automatic send_tx(input logic m, input logic p, input logic b);
    @(posedge clk);
    tx_in <= {1'b1, m, p, b};
    @(posedge clk);
    tx_in <= {1'b0, ~m, ~p, ~b};
  endtask : send_tx

  // One received pattern logic error.
  task automatic pulse_prbs();
    @(posedge clk);
    prbs_error <= 1'b1;
    @(posedge clk);
    prbs_error <= 1'b0;
  endtask : pulse_prbs
endmodule : line_partner
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     clk, arst_n, single_rail, reg_wr, reg_rd, vio, irq;
  logic [7:0]               reg_addr, reg_wdata, reg_rdata, d, pol_bits;
  line_err_pkg::line_code_e coding;
  line_err_pkg::rx_sym_s    rx_sym;
  line_err_pkg::tx_sym_s    tx_in, tx_out;
  logic                     prbs_error;
  int                       mismatches, checks_done, vp_cnt, marks, prbs_ones;

  line_partner far_end (.clk(clk), .rx_sym(rx_sym), .tx_in(tx_in), .prbs_error(prbs_error));
  line_error_counter_injector #(.CNT_W(16), .SECOND_CYCLES(50)) dut (
    .clk(clk), .arst_n(arst_n), .ce(1'b1), .coding(coding), .single_rail(single_rail),
    .rx_sym(rx_sym), .prbs_error(prbs_error), .tx_in(tx_in), .tx_out(tx_out),
    .violation_pulse_output(vio), .irq(irq), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // ----------------------------------------------------------------------
  // Clock, monitors and bus tasks
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pin pulses and transmitted marks are tallied at every rising edge.
  always @(posedge clk) begin
    if (vio === 1'b1) vp_cnt++;
    if (tx_out.valid === 1'b1 && tx_out.mark === 1'b1) begin
      marks++;
      pol_bits <= {pol_bits[6:0], tx_out.pol};
    end
    if (tx_out.valid === 1'b1 && tx_out.prbs === 1'b1) prbs_ones++;
  end

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data lands at the edge that takes the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic results();
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // A hang anywhere counts against the run.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    single_rail = 1'b1;
    coding = line_err_pkg::CODE_AMI;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(line_err_pkg::ADDR_STATUS);
    chk("status_reset", d, 8'h00);
    rd(line_err_pkg::ADDR_CTRL);
    chk("ctrl_reset", d, line_err_pkg::CTRL_RESET);
    rd(line_err_pkg::ADDR_IE);
    chk("ie_reset", d, line_err_pkg::IE_RESET);
    // Two equal marks in AMI; the violation source starts masked.
    wr(line_err_pkg::ADDR_IE, 8'h08);
    wr(line_err_pkg::ADDR_CTRL, 8'h20);
    far_end.send_rx(1'b1, 1'b1, 1'b0);
    far_end.send_rx(1'b1, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    chk("pin_cycles", vp_cnt[7:0], 8'h01);
    chk("irq_masked", {7'h00, irq}, 8'h00);
    wr(line_err_pkg::ADDR_IE, 8'h0a);
    #1 chk("irq_on", {7'h00, irq}, 8'h01);
    rd(line_err_pkg::ADDR_STATUS);
    chk("viol_status", d & 8'h07, 8'h02);
    #1 chk("irq_cleared", {7'h00, irq}, 8'h00);
    wr(line_err_pkg::ADDR_CTRL, 8'h24);
    repeat (2) @(posedge clk);
    wr(line_err_pkg::ADDR_CNT_LO, 8'hff);
    rd(line_err_pkg::ADDR_CNT_LO);
    chk("manual_lo", d, 8'h01);
    rd(line_err_pkg::ADDR_CNT_HI);
    chk("manual_hi", d, 8'h00);
    rd(8'h40);
    chk("unmapped", d, 8'h00);
    // HDB3 zero runs: four zeros is an error, three is not.
    coding <= line_err_pkg::CODE_HDB3;
    wr(line_err_pkg::ADDR_CTRL, 8'h40);
    far_end.send_rx(1'b1, 1'b0, 1'b0);
    repeat (4) far_end.send_rx(1'b0, 1'b0, 1'b0);
    far_end.send_rx(1'b1, 1'b1, 1'b0);
    repeat (3) far_end.send_rx(1'b0, 1'b0, 1'b0);
    far_end.send_rx(1'b1, 1'b0, 1'b0);
    // Two equal-polarity violations make one code violation; a substitution pulse does not.
    far_end.send_rx(1'b1, 1'b0, 1'b0);
    far_end.send_rx(1'b1, 1'b1, 1'b0);
    far_end.send_rx(1'b1, 1'b0, 1'b0);
    far_end.send_rx(1'b1, 1'b0, 1'b0);
    far_end.send_rx(1'b1, 1'b0, 1'b1);
    repeat (3) @(posedge clk);
    chk("cv_pin", vp_cnt[7:0], 8'h02);
    rd(line_err_pkg::ADDR_STATUS);
    chk("exz_status", d & 8'h04, 8'h04);
    wr(line_err_pkg::ADDR_CTRL, 8'h44);
    repeat (2) @(posedge clk);
    rd(line_err_pkg::ADDR_CNT_LO);
    chk("exz_count", d, 8'h01);
    // Automatic reporting of pattern errors over one short period.
    wr(line_err_pkg::ADDR_CTRL, 8'h02);
    repeat (3) far_end.pulse_prbs();
    repeat (50) @(posedge clk);
    rd(line_err_pkg::ADDR_CNT_LO);
    chk("auto_lo", d, 8'h03);
    rd(line_err_pkg::ADDR_STATUS);
    chk("timer_status", d & 8'h08, 8'h08);
    // Both insert triggers, then five alternating marks.
    wr(line_err_pkg::ADDR_CTRL, 8'h18);
    far_end.send_tx(1'b1, 1'b1, 1'b0);
    far_end.send_tx(1'b1, 1'b0, 1'b0);
    far_end.send_tx(1'b1, 1'b1, 1'b0);
    far_end.send_tx(1'b1, 1'b0, 1'b0);
    far_end.send_tx(1'b1, 1'b1, 1'b0);
    repeat (3) far_end.send_tx(1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    chk("tx_marks", marks[7:0], 8'h05);
    chk("tx_pols", {3'h0, pol_bits[4:0]}, 8'h1d);
    chk("tx_flips", prbs_ones[7:0], 8'h01);
    results();
  end
endmodule : testbench
`default_nettype wire
